// File: hdl/camera_input_map.vh
// Purpose: Named constants for the parallel camera input block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef CAMERA_INPUT_MAP_VH
`define CAMERA_INPUT_MAP_VH
// Format codes
`define FMT_CCIR656 4'h0
`define FMT_GEN10 4'h1
`define FMT_YC2CYC 4'h2
`define FMT_YC1CYC 4'h3
`define FMT_RGB565 4'h4
`define FMT_RGB666 4'h5
`define FMT_RGB3CYC 4'h6
`define FMT_RGB888 4'h7
`define FMT_TVDEC 4'h8
// Lane fields
`define LANE8_HI 9
`define LANE8_LO 2
`define LANE10_HI 9
`define LANE16_HI 15
`define LANE24_HI 23
`define LANE_ZERO 0
`define LANE_B0_HI 7
`define LANE_B1_LO 8
`define LANE_B1_HI 15
`define LANE_B2_LO 16
// Five six five fields
`define R565_B_HI 4
`define R565_G_LO 5
`define R565_G_HI 10
`define R565_R_LO 11
// Six six six fields, low ends
`define R666_B_LO 2
`define R666_G_LO 10
`define R666_R_LO 18
// Assembled word layout
`define WD_WIDTH 30
`define WD_FRAME 29
`define WD_LINE 28
`define WD_FIELD 27
`define WD_C2_HI 26
`define WD_C2_LO 19
`define WD_C1_HI 18
`define WD_C1_LO 11
`define WD_C0_HI 10
`define WD_C0_LO 3
// Capture cycle counts per pixel
`define CNT_ONE 2'h0
`define CNT_TWO 2'h1
`define CNT_THREE 2'h2
// Master clock divider half period, less one, in mclk cycles
`define MCLK_HALF_DIV 4'h1
`endif

// File: hdl/parallel_camera_input.v
// Purpose: Parallel camera input, lane mapping per pixel format
// Assumes: Pixel clock much slower than mclk; sampled as a plain input
// Notes: Sensor keeps its data on the lanes each format assigns
// How it works
// - Field input is sampled and reported with each pixel.
// - Horizontal sync marks line boundaries.
// - Vertical sync marks start of frame.
// - Device drives master clock out to the sensor.
// - Lanes captured on pixel clock rising edges; syncs sampled on every mclk.
// - Multi-cycle formats take one byte per clock on 9..2.
`timescale 1ns/1ns
`include "camera_input_map.vh"
module parallel_camera_input #(
   parameter LANES = 24
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Format select
   input wire [3:0] pixelFormat,
   // Sensor pins
   input wire pixel_clock_in,
   input wire [LANES-1:0] cameraData,
   input wire hsyncIn,
   input wire vsyncIn,
   input wire fieldIn,
   output reg sensorMclk,
   // Pixel stream out
   output wire pixValid,
   input wire pixReady,
   output wire [7:0] pixComp0,
   output wire [7:0] pixComp1,
   output wire [7:0] pixComp2,
   output wire pixStartFrame,
   output wire pixStartLine,
   output wire pixField,
   output wire overflow
);
   localparam W = `WD_WIDTH;
   reg [2:0] clkSync;
   reg [LANES-1:0] dataS1;
   reg [LANES-1:0] dataS2;
   reg [LANES-1:0] dataS3;
   reg [2:0] hsS;
   reg [2:0] vsS;
   reg [2:0] fdS;
   reg clkState;
   reg hsState;
   reg vsState;
   reg fdState;
   reg lineArmed;
   reg frameArmed;
   reg [1:0] phase;
   reg [7:0] hold0;
   reg [7:0] hold1;
   reg [7:0] next_c0;
   reg [7:0] next_c1;
   reg [7:0] next_c2;
   reg [1:0] lastPhase;
   reg wordValid;
   reg [W-1:0] word;
   reg overflowFlag;
   reg [3:0] divCount;
   wire [23:0] lane;
   wire clkRise;
   wire bufReady;
   wire [W-1:0] bufOut;
   wire [7:0] byteIn;

   // Pad unused lanes with zero
   assign lane[LANES-1:0] = dataS3;
   generate
      if (LANES < 24) begin : g_pad
         assign lane[23:LANES] = {(24-LANES){1'b0}};
      end
   endgenerate

   // Three-stage input synchronisers
   always @(posedge mclk) begin
      if (!rst_n) begin
         clkSync <= 3'h0;
         hsS <= 3'h0;
         vsS <= 3'h0;
         fdS <= 3'h0;
         dataS1 <= {LANES{1'b0}};
         dataS2 <= {LANES{1'b0}};
         dataS3 <= {LANES{1'b0}};
      end else begin
         clkSync <= {clkSync[1:0], pixel_clock_in};
         hsS <= {hsS[1:0], hsyncIn};
         vsS <= {vsS[1:0], vsyncIn};
         fdS <= {fdS[1:0], fieldIn};
         dataS1 <= cameraData;
         dataS2 <= dataS1;
         dataS3 <= dataS2;
      end
   end

   // Filtered levels: change once stages two and three agree
   always @(posedge mclk) begin
      if (!rst_n) begin
         clkState <= 1'b0;
         hsState <= 1'b0;
         vsState <= 1'b0;
         fdState <= 1'b0;
      end else begin
         if (clkSync[1] == clkSync[2]) clkState <= clkSync[2];
         if (hsS[1] == hsS[2]) hsState <= hsS[2];
         if (vsS[1] == vsS[2]) vsState <= vsS[2];
         if (fdS[1] == fdS[2]) fdState <= fdS[2];
      end
   end

   assign clkRise = (clkSync[1] == clkSync[2]) && clkSync[2] && !clkState;

   assign byteIn = lane[`LANE8_HI:`LANE8_LO];

   // Capture cycles per pixel for the format
   always @* begin
      case (pixelFormat)
         `FMT_CCIR656: lastPhase = `CNT_TWO;
         `FMT_YC2CYC: lastPhase = `CNT_TWO;
         `FMT_RGB3CYC: lastPhase = `CNT_THREE;
         default: lastPhase = `CNT_ONE;
      endcase
   end

   // Lane to component mapping
   always @* begin
      next_c0 = 8'h00;
      next_c1 = 8'h00;
      next_c2 = 8'h00;
      case (pixelFormat)
         `FMT_CCIR656, `FMT_YC2CYC: begin
            next_c0 = hold0;
            next_c1 = byteIn;
         end
         `FMT_RGB3CYC: begin
            next_c0 = hold0;
            next_c1 = hold1;
            next_c2 = byteIn;
         end
         `FMT_GEN10: begin
            next_c0 = lane[`LANE_B0_HI:`LANE_ZERO];
            next_c1 = {6'h00, lane[`LANE10_HI:`LANE_B1_LO]};
         end
         `FMT_YC1CYC: begin
            next_c0 = lane[`LANE_B0_HI:`LANE_ZERO];
            next_c1 = lane[`LANE16_HI:`LANE_B1_LO];
         end
         `FMT_RGB565: begin
            next_c0 = {3'h0, lane[`R565_B_HI:`LANE_ZERO]};
            next_c1 = {2'h0, lane[`R565_G_HI:`R565_G_LO]};
            next_c2 = {3'h0, lane[`LANE16_HI:`R565_R_LO]};
         end
         // Six six six: B 7..2, G 15..10, R 23..18
         `FMT_RGB666: begin
            next_c0 = {2'h0, lane[`LANE_B0_HI:`R666_B_LO]};
            next_c1 = {2'h0, lane[`LANE16_HI:`R666_G_LO]};
            next_c2 = {2'h0, lane[`LANE24_HI:`R666_R_LO]};
         end
         `FMT_RGB888: begin
            next_c0 = lane[`LANE_B0_HI:`LANE_ZERO];
            next_c1 = lane[`LANE_B1_HI:`LANE_B1_LO];
            next_c2 = lane[`LANE24_HI:`LANE_B2_LO];
         end
         `FMT_TVDEC: begin
            next_c0 = lane[`LANE_B0_HI:`LANE_ZERO];
            next_c1 = lane[`LANE_B1_HI:`LANE_B1_LO];
            next_c2 = lane[`LANE24_HI:`LANE_B2_LO];
         end
         default: begin
            next_c0 = 8'h00;
         end
      endcase
   end

   // Capture, assemble and mark syncs
   always @(posedge mclk) begin
      if (!rst_n) begin
         phase <= 2'h0;
         hold0 <= 8'h00;
         hold1 <= 8'h00;
         wordValid <= 1'b0;
         word <= {W{1'b0}};
         lineArmed <= 1'b0;
         frameArmed <= 1'b0;
         overflowFlag <= 1'b0;
      end else begin
         wordValid <= 1'b0;
         if (vsState) begin
            frameArmed <= 1'b1;
            phase <= 2'h0;
         end
         if (!hsState) begin
            lineArmed <= 1'b1;
            phase <= 2'h0;
         end
         if (clkRise && hsState && !vsState) begin
            if (phase != lastPhase) begin
               if (phase == 2'h0) hold0 <= byteIn;
               else hold1 <= byteIn;
               phase <= phase + 2'h1;
            end else begin
               phase <= 2'h0;
               wordValid <= 1'b1;
               word <= {frameArmed, lineArmed, fdState,
                        next_c2, next_c1, next_c0, 3'h0};
               frameArmed <= 1'b0;
               lineArmed <= 1'b0;
            end
         end
         // Sticky when a word is dropped for lack of room
         if (wordValid && !bufReady) overflowFlag <= 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         divCount <= 4'h0;
         sensorMclk <= 1'b0;
      end else if (divCount == `MCLK_HALF_DIV) begin
         divCount <= 4'h0;
         sensorMclk <= !sensorMclk;
      end else begin
         divCount <= divCount + 4'h1;
      end
   end

   pixel_buffer #(
      .WIDTH(W)
   ) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .inValid(wordValid),
      .inReady(bufReady),
      .inData(word),
      .outValid(pixValid),
      .outReady(pixReady),
      .outData(bufOut)
   );

   // Output fields
   assign pixStartFrame = bufOut[`WD_FRAME];
   assign pixStartLine = bufOut[`WD_LINE];
   assign pixField = bufOut[`WD_FIELD];
   assign pixComp2 = bufOut[`WD_C2_HI:`WD_C2_LO];
   assign pixComp1 = bufOut[`WD_C1_HI:`WD_C1_LO];
   assign pixComp0 = bufOut[`WD_C0_HI:`WD_C0_LO];
   assign overflow = overflowFlag;
endmodule // parallel_camera_input

// File: hdl/pixel_buffer.v
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock mclk, synchronous active-low reset
// Notes: Full when two words are held; drain may stall
`timescale 1ns/1ns
module pixel_buffer #(
   parameter WIDTH = 30
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // Drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] slot0;
   reg [WIDTH-1:0] slot1;
   reg [1:0] count;
   wire push;
   wire pop;

   // Handshake terms
   assign inReady = (count != 2'h2);
   assign outValid = (count != 2'h0);
   assign outData = slot0;
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Storage and occupancy
   always @(posedge mclk) begin
      if (!rst_n) begin
         count <= 2'h0;
         slot0 <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
      end else begin
         if (pop) begin
            slot0 <= slot1;
         end
         if (push) begin
            if (count == 2'h0 || (count == 2'h1 && pop)) begin
               slot0 <= inData;
            end else begin
               slot1 <= inData;
            end
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // pixel_buffer

// File: verification/camera_sensor_model.sv
// Purpose: Behavioural parallel image sensor
// Assumes: Driven by bench tasks, times in ns
// Notes: Pixel clock stands low between words
`timescale 1ns/1ns
module camera_sensor_model (
   // Sensor pins
   output logic pixClk,
   output logic [23:0] laneData,
   output logic hsync,
   output logic vsync,
   output logic field
);
   // Idle levels
   initial begin
      pixClk = 1'b0;
      laneData = 24'h0;
      hsync = 1'b0;
      vsync = 1'b0;
      field = 1'b0;
   end
   // Frame start, field held all frame
   task frame(input logic f);
      hsync = 1'b0;
      vsync = 1'b1;
      field = f;
      #2000 vsync = 1'b0;
      #1000 hsync = 1'b1;
   endtask
   // Line gap
   task line();
      hsync = 1'b0;
      #1000 hsync = 1'b1;
   endtask
   // One word; unused lanes carry junk
   task word(input int w, input logic [23:0] v);
      laneData = ~laneData;
      case (w)
         8: laneData[9:2] = v[7:0];
         10: laneData[9:0] = v[9:0];
         16: laneData[15:0] = v[15:0];
         default: laneData = v;
      endcase
      #400 pixClk = 1'b1;
      #400 pixClk = 1'b0;
      laneData = ~laneData;
   endtask
endmodule // camera_sensor_model

// File: verification/parallel_camera_input_assertions.sv
// Purpose: Port checks on the camera input
// Assumes: One mclk domain, synchronous reset
// Notes: Bound to parallel_camera_input
`timescale 1ns/1ns
module parallel_camera_input_assertions (
   // Clock and reset
   input logic mclk,
   input logic rst_n,
   // Sensor side
   input logic pixel_clock_in,
   input logic vsyncIn,
   input logic fieldIn,
   input logic sensorMclk,
   // Stream side
   input logic pixValid,
   input logic pixReady,
   input logic [7:0] pixComp0,
   input logic [7:0] pixComp1,
   input logic [7:0] pixComp2,
   input logic pixStartFrame,
   input logic pixStartLine,
   input logic pixField,
   input logic overflow
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Clock out, stream hold and framing
   a_mclk_rate: assert property ($changed(sensorMclk) |=>
      $stable(sensorMclk) ##1 $changed(sensorMclk)) else $error("mclk rate");
   a_word_stands: assert property (pixValid && !pixReady |=>
      pixValid && $stable({pixComp0, pixComp1, pixComp2, pixStartFrame,
      pixStartLine, pixField})) else $error("word changed");
   a_field_match: assert property ($rose(pixValid) &&
      fieldIn == $past(fieldIn, 8) |-> pixField == fieldIn)
      else $error("field wrong");
   a_frame_line: assert property (pixValid && pixStartFrame
      |-> pixStartLine) else $error("frame without line");
   a_blank_idle: assert property (vsyncIn [*8] ##1 !pixValid
      |=> !pixValid) else $error("word in blank");
   a_pclk_quiet: assert property ($stable(pixel_clock_in) [*8]
      ##1 !pixValid |=> !pixValid) else $error("word without pclk");
   a_line_once: assert property (pixValid && pixReady &&
      pixStartLine |=> !(pixValid && pixStartLine)) else $error("line twice");
   a_ovf_sticky: assert property (overflow |=> overflow)
      else $error("overflow cleared");
   a_ovf_cause: assert property ($rose(overflow) |->
      $past(pixValid && !pixReady)) else $error("overflow no stall");
   // Main scenarios reached
   c_frame: cover property (pixValid && pixReady && pixStartFrame);
   c_stall: cover property (pixValid && !pixReady ##1 pixValid);
   c_full: cover property ($rose(overflow));
endmodule // parallel_camera_input_assertions
bind parallel_camera_input parallel_camera_input_assertions u_chk (
   .mclk(mclk), .rst_n(rst_n), .pixel_clock_in(pixel_clock_in),
   .vsyncIn(vsyncIn), .fieldIn(fieldIn), .sensorMclk(sensorMclk),
   .pixValid(pixValid), .pixReady(pixReady), .pixComp0(pixComp0),
   .pixComp1(pixComp1), .pixComp2(pixComp2), .pixField(pixField),
   .pixStartFrame(pixStartFrame), .pixStartLine(pixStartLine),
   .overflow(overflow));

// File: verification/parallel_camera_input_mapping_test.sv
// Purpose: Self-checking bench for the camera input
// Assumes: Sensor model drives the pins
// Notes: Sink stalls while words are sent
`timescale 1ns/1ns
`include "camera_input_map.vh"
module parallel_camera_input_mapping_test;
   logic mclk = 1'b0;
   logic rst_n;
   logic pixReady;
   logic [3:0] pixelFormat;
   wire pixClk, hsync, vsync, field, sensorMclk, pixValid, overflow;
   wire pixStartFrame, pixStartLine, pixField;
   wire [23:0] laneData;
   wire [7:0] pixComp0, pixComp1, pixComp2;
   int errors = 0;
   int n_compared = 0;
   // Clock, design and sensor
   always #50 mclk = ~mclk;
   parallel_camera_input DUT (.mclk(mclk), .rst_n(rst_n),
      .pixelFormat(pixelFormat), .pixel_clock_in(pixClk),
      .cameraData(laneData), .hsyncIn(hsync), .vsyncIn(vsync),
      .fieldIn(field), .sensorMclk(sensorMclk), .pixValid(pixValid),
      .pixReady(pixReady), .pixComp0(pixComp0), .pixComp1(pixComp1),
      .pixComp2(pixComp2), .pixStartFrame(pixStartFrame),
      .pixStartLine(pixStartLine), .pixField(pixField),
      .overflow(overflow));
   camera_sensor_model sensor (.pixClk(pixClk), .laneData(laneData),
      .hsync(hsync), .vsync(vsync), .field(field));
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task summarize;
      if (errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Wait for a word, compare, then pop it
   task take(input logic [23:0] e, m, input logic [2:0] fl);
      int i;
      for (i = 0; i < 60 && pixValid !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      check({pixComp2, pixComp1, pixComp0} & m, e & m);
      check({pixValid, pixStartFrame, pixStartLine, pixField}, {1'b1, fl});
      pixReady = 1'b1;
      @(posedge mclk);
      #1 pixReady = 1'b0;
   endtask
   task run(input logic [3:0] fmt, input int w, n,
      input logic [23:0] d, e, m, input logic f);
      int k;
      pixelFormat = fmt;
      sensor.frame(f);
      for (k = 0; k < n; k++) sensor.word(w, d >> (8 * k));
      take(e, m, {2'b11, f});
   endtask
   task t_mclk;
      logic [7:0] s;
      int i;
      for (i = 0; i < 8; i++) begin
         @(posedge mclk);
         #1 s[i] = sensorMclk;
      end
      check(s[7:2], {~s[5:0]});
      check(^s, 1'b0);
   endtask
   task t_lanes;
      run(`FMT_GEN10, 10, 1, 24'h2d6, 24'h2d6, 24'h3ff, 1'b0);
      run(`FMT_YC2CYC, 8, 2, 24'he13c, 24'he13c, 24'hffff, 1'b1);
      run(`FMT_CCIR656, 8, 2, 24'h5aa5, 24'h5aa5, '1, 1'b0);
      run(`FMT_YC1CYC, 16, 1, 24'hb64d, 24'hb64d, 24'hffff, 1'b0);
      run(`FMT_RGB888, 24, 1, 24'h9cb64d, 24'h9cb64d, '1, 1'b1);
   endtask
   task t_one_cycle;
      run(`FMT_RGB565, 16, 1, 24'hb64d, 24'h16320d, 24'h1f3f1f, 0);
      run(`FMT_TVDEC, 24, 1, 24'h9cb64d, 24'h9cb64d, '1, 1'b1);
      run(`FMT_RGB666, 24, 1, 24'he854ac, 24'h3a152b, '1, 1'b0);
   endtask
   // Back-to-back pixels, broken pixel, new line
   task t_lines;
      int k;
      pixelFormat = `FMT_RGB3CYC;
      sensor.frame(1'b1);
      for (k = 0; k < 6; k++) sensor.word(8, 48'hc6a5e47b1e3c >> (8 * k));
      take(24'h7b1e3c, '1, 3'b111);
      take(24'hc6a5e4, '1, 3'b001);
      sensor.word(8, 24'h99);
      sensor.line();
      for (k = 0; k < 3; k++) sensor.word(8, 24'h0f1e2d >> (8 * k));
      take(24'h0f1e2d, '1, 3'b011);
   endtask
   // Fill past two words with the sink stalled
   task t_full;
      pixelFormat = `FMT_RGB888;
      sensor.frame(1'b0);
      sensor.word(24, 24'h123456);
      sensor.word(24, 24'h789abc);
      sensor.word(24, 24'hdef012);
      // Dropped word reaches the flag a few cycles after the pulse
      repeat (4) @(posedge mclk);
      #1;
      check(overflow, 1'b1);
      take(24'h123456, '1, 3'b110);
      take(24'h789abc, '1, 3'b000);
      check(pixValid, 1'b0);
   endtask
   // Reset, then scenarios
   initial begin
      rst_n = 1'b0;
      pixReady = 1'b0;
      pixelFormat = 4'h0;
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge mclk);
      #1 t_mclk();
      t_lanes();
      t_one_cycle();
      t_lines();
      t_full();
      summarize();
   end
   // Watchdog
   initial begin
      #200000;
      errors++;
      summarize();
   end
endmodule // parallel_camera_input_mapping_test
